//--- inc/fsr_pkg.sv
// Constants and carrier types for the flash status and read command block
package fsr_pkg;
	// Opcodes
	localparam logic [7:0] OP_WREN     = 8'h06;
	localparam logic [7:0] OP_VOL_WREN = 8'h50;
	localparam logic [7:0] OP_WRDI     = 8'h04;
	localparam logic [7:0] OP_RDSR1    = 8'h05;
	localparam logic [7:0] OP_RDSR2    = 8'h35;
	localparam logic [7:0] OP_RDSR3    = 8'h15;
	localparam logic [7:0] OP_WRSR1    = 8'h01;
	localparam logic [7:0] OP_WRSR2    = 8'h31;
	localparam logic [7:0] OP_WRSR3    = 8'h11;
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_FAST     = 8'h0b;
	// Bit counts of the serial frame
	localparam logic [4:0] OPC_BITS  = 5'h08;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [4:0] STEP_SPI  = 5'h01;
	localparam logic [4:0] STEP_QUAD = 5'h04;
	// Dummy clocks: standard mode fixed, quad mode 2 + 2 * parameter
	localparam logic [3:0] DUMMY_SPI  = 4'h8;
	localparam logic [3:0] DUMMY_BASE = 4'h2;
	// Status word layout (register three : two : one)
	localparam int BIT_BUSY = 0;
	localparam int BIT_WEL  = 1;
	localparam logic [23:0] WRITABLE_MASK = 24'he07bfc;
	localparam logic [23:0] OTP_MASK      = 24'h003900;
	localparam logic [23:0] QE_MASK       = 24'h000200;
	localparam logic [23:0] SR1_MASK      = 24'h0000ff;
	localparam logic [23:0] SR2_MASK      = 24'h00ff00;
	localparam logic [23:0] SR3_MASK      = 24'hff0000;
	localparam logic [23:0] NV_RESET      = 24'h000000;
	localparam logic [1:0]  PARAM_RESET   = 2'h0;
	// Timing
	localparam int CLK_PERIOD_NS       = 10;
	localparam int WRITE_CYCLE_TIME_US = 5;
	localparam int WRITE_CYCLES        = WRITE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int REFRESH_TIME_NS     = 50;
	localparam int REFRESH_CYCLES_RAW  = REFRESH_TIME_NS / CLK_PERIOD_NS;
	localparam int REFRESH_CYCLES      = (REFRESH_CYCLES_RAW < 1) ? 1 : REFRESH_CYCLES_RAW;
	// Pins from the host, sampled together
	typedef struct packed {
		logic       csN;
		logic       sclk;
		logic [3:0] io;
	} fsr_pins_s;
endpackage

//--- rtl/fsr_cmd_core.sv
// Serial flash instruction handler: write latch, status access and reads
`timescale 1ns/1ps
`default_nettype none
module fsr_cmd_core #(
	parameter int unsigned WRITE_CYCLES = fsr_pkg::WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              nrst,
	// Host pins (io[0] is serial_in); enables are active low
	input  wire fsr_pkg::fsr_pins_s pins,
	output logic [3:0]             ioOut,
	output logic [3:0]             ioOeN,
	// Mode and configuration from neighbouring logic
	input  wire logic              quadMode,
	input  wire logic              readParamLoad,
	input  wire logic [1:0]        readParamIn,
	input  wire logic              resetCmd,
	// Memory array read port, data valid one clock after address
	output logic [23:0]            memAddr,
	input  wire logic [7:0]        memRdData,
	// Program and erase engine
	input  wire logic              extBusy,
	input  wire logic              extDone,
	// Status word including busy and write latch flag
	output logic [23:0]            statusWord
);
	typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_OUT, ST_WRD, ST_IGN} fsr_state_e;

	// Masked status merge honouring one-time and quad-mode locks
	function automatic logic [23:0] mergeStatus(input logic [23:0] old, input logic [23:0] val,
		input logic [23:0] mask, input logic quad);
		logic [23:0] wmask;
		// Read-only positions (busy, latch, reserved) never follow the data
		wmask = mask & fsr_pkg::WRITABLE_MASK & ~(quad ? fsr_pkg::QE_MASK : 24'h000000);
		return (old & ~wmask) | (val & wmask) | (old & fsr_pkg::OTP_MASK);
	endfunction

	// Synchroniser stages: stage one feeds stage two only
	fsr_pkg::fsr_pins_s pinS1;
	fsr_pkg::fsr_pins_s pinS2;
	fsr_pkg::fsr_pins_s pinS3;    // Delayed copy for edge detection
	fsr_state_e         state;
	logic [23:0]        sh;       // Input shift register
	logic [4:0]         cnt;      // Bits received in this phase
	logic [3:0]         dummyCnt; // Remaining dummy clocks
	logic [7:0]         outSh;    // Output shift register
	logic [3:0]         outCnt;   // Bits left in the current byte
	logic               isStatus; // Output source is a status byte
	logic [1:0]         srSel;    // Status register being read
	logic               isFast;
	logic               write_latch_flag;
	logic               volEn;    // Volatile write enable pending
	logic               wrPend;   // Status write opcode accepted
	logic               wrVol;
	logic [23:0]        wrMask;   // Registers addressed by the write
	logic [7:0]         wrLo;
	logic [7:0]         wrHi;
	logic [1:0]         wrBytes;
	logic [23:0]        nvSr;     // Stored copy
	logic [23:0]        activeSr; // Copy in force
	logic [23:0]        pendVal;  // Value waiting for its cycle end
	logic [19:0]        busyCnt;
	logic [3:0]         refreshCnt;
	logic [1:0]         readParam;

	// Edge and frame decode
	wire        sclkRise  = pinS2.sclk & ~pinS3.sclk;
	wire        sclkFall  = ~pinS2.sclk & pinS3.sclk;
	wire        csHigh    = pinS2.csN;
	wire        csRise    = pinS2.csN & ~pinS3.csN;
	wire [4:0]  step      = quadMode ? fsr_pkg::STEP_QUAD : fsr_pkg::STEP_SPI;
	wire [4:0]  cntNext   = cnt + step;
	wire [23:0] shNext    = quadMode ? {sh[19:0], pinS2.io} : {sh[22:0], pinS2.io[0]};
	wire [7:0]  opcode    = shNext[7:0];
	wire        busyNow   = (busyCnt != 20'h00000) | extBusy;
	wire        rise      = sclkRise & ~csHigh;
	wire        opcDone   = rise & (state == ST_OPC) & (cntNext == fsr_pkg::OPC_BITS);
	wire        addrDone  = rise & (state == ST_ADDR) & (cntNext == fsr_pkg::ADDR_BITS);
	wire        isRdsr    = (opcode == fsr_pkg::OP_RDSR1) | (opcode == fsr_pkg::OP_RDSR2)
		| (opcode == fsr_pkg::OP_RDSR3);
	wire        isWrsr    = (opcode == fsr_pkg::OP_WRSR1) | (opcode == fsr_pkg::OP_WRSR2)
		| (opcode == fsr_pkg::OP_WRSR3);
	wire        wrsrOk    = isWrsr & ~busyNow & (write_latch_flag | volEn);
	wire        readOk    = ((opcode == fsr_pkg::OP_READ) & ~quadMode
		| (opcode == fsr_pkg::OP_FAST)) & ~busyNow;
	wire [1:0]  selOfOpc  = (opcode == fsr_pkg::OP_RDSR2) ? 2'h1
		: (opcode == fsr_pkg::OP_RDSR3) ? 2'h2 : 2'h0;
	wire [23:0] maskOfOpc = (opcode == fsr_pkg::OP_WRSR2) ? fsr_pkg::SR2_MASK
		: (opcode == fsr_pkg::OP_WRSR3) ? fsr_pkg::SR3_MASK : fsr_pkg::SR1_MASK;
	// Legacy two-byte write widens the mask to registers one and two
	wire [23:0] fullMask  = (wrBytes == 2'h2) ? (fsr_pkg::SR1_MASK | fsr_pkg::SR2_MASK) : wrMask;
	wire [23:0] wrData    = (wrMask == fsr_pkg::SR1_MASK) ? {8'h00, wrHi, wrLo} : {wrLo, wrLo, wrLo};
	wire [23:0] merged    = mergeStatus(activeSr, wrData, fullMask, quadMode);
	wire        commit    = csRise & wrPend & (wrBytes != 2'h0);
	wire [23:0] curStatus = {activeSr[23:2], write_latch_flag, busyNow};
	wire [7:0]  srByte    = (srSel == 2'h1) ? statusWord[15:8]
		: (srSel == 2'h2) ? statusWord[23:16] : statusWord[7:0];
	wire [7:0]  nextByte  = isStatus ? srByte : memRdData;
	wire [3:0]  dummyLoad = quadMode ? fsr_pkg::DUMMY_BASE + {1'b0, readParam, 1'b0}
		: fsr_pkg::DUMMY_SPI;
	wire        nvEnd     = busyCnt == 20'h00001;
	wire        volEnd    = refreshCnt == 4'h1;

	// Two-flop synchroniser plus one delay stage for edges
	always_ff @(posedge clock) begin
		pinS1 <= pins;
		pinS2 <= pinS1;
		pinS3 <= pinS2;
	end

	// Frame sequencer: opcode, address, dummy, data phases
	always_ff @(posedge clock) begin
		if (!nrst || csHigh) begin
			state <= ST_OPC;
			cnt <= 5'h00;
		end else if (rise) begin
			cnt <= cntNext;
			unique case (state)
				ST_OPC: begin
					if (cntNext == fsr_pkg::OPC_BITS) begin
						cnt <= 5'h00;
						if (isRdsr) begin
							state <= ST_OUT;
						end else if (wrsrOk) begin
							state <= ST_WRD;
						end else if (readOk) begin
							state <= ST_ADDR;
						end else begin
							state <= ST_IGN;
						end
					end
				end
				ST_ADDR: begin
					if (cntNext == fsr_pkg::ADDR_BITS) begin
						state <= isFast ? ST_DUMMY : ST_OUT;
					end
				end
				ST_DUMMY: begin
					if (dummyCnt == 4'h1) begin
						state <= ST_OUT;
					end
				end
				ST_WRD: begin
					if (cntNext == fsr_pkg::WORD_BITS) begin // Bits past sixteen are dropped
						state <= ST_IGN;
					end
				end
				ST_OUT, ST_IGN: begin
					cnt <= cnt;
				end
			endcase
		end
	end

	// Input shift register and per-command context
	always_ff @(posedge clock) begin
		if (!nrst) begin
			sh <= 24'h000000;
			isStatus <= 1'b0;
			srSel <= 2'h0;
			isFast <= 1'b0;
			dummyCnt <= 4'h0;
		end else if (rise) begin
			sh <= shNext;
			if (opcDone) begin
				isStatus <= isRdsr;
				srSel <= selOfOpc;
				isFast <= opcode == fsr_pkg::OP_FAST;
				dummyCnt <= dummyLoad;
			end else if (state == ST_DUMMY) begin
				dummyCnt <= dummyCnt - 4'h1;
			end
		end
	end

	// Output shifter: a new byte on the fall after each byte ends
	always_ff @(posedge clock) begin
		if (!nrst || csHigh) begin
			ioOut <= 4'h0;
			ioOeN <= 4'hf;
			outSh <= 8'h00;
			outCnt <= 4'h0;
		end else if (sclkFall && state == ST_OUT) begin
			ioOeN <= quadMode ? 4'h0 : 4'hd;
			if (outCnt == 4'h0) begin
				// Status bytes repeat; array bytes advance
				ioOut <= quadMode ? nextByte[7:4] : {2'h0, nextByte[7], 1'b0};
				outSh <= nextByte << step[2:0];
				outCnt <= 4'h8 - step[3:0];
			end else begin
				ioOut <= quadMode ? outSh[7:4] : {2'h0, outSh[7], 1'b0};
				outSh <= outSh << step[2:0];
				outCnt <= outCnt - step[3:0];
			end
		end
	end

	// Array address: loaded from the frame, bumped per byte taken
	always_ff @(posedge clock) begin
		if (!nrst) begin
			memAddr <= 24'h000000;
		end else if (addrDone) begin
			memAddr <= shNext;
		end else if (sclkFall && !csHigh && state == ST_OUT && !isStatus && outCnt == 4'h0) begin
			memAddr <= memAddr + 24'h000001;
		end
	end

	// Status write capture; write context dies with the frame
	always_ff @(posedge clock) begin
		if (!nrst || csRise) begin
			wrPend <= 1'b0;
			wrBytes <= 2'h0;
			wrVol <= 1'b0;
			wrMask <= fsr_pkg::SR1_MASK;
			wrLo <= 8'h00;
			wrHi <= 8'h00;
		end else if (opcDone && wrsrOk) begin
			wrPend <= 1'b1;
			wrVol <= ~write_latch_flag;
			wrMask <= maskOfOpc;
		end else if (rise && state == ST_WRD) begin
			if (cntNext == fsr_pkg::BYTE_BITS) begin
				wrLo <= shNext[7:0];
				wrBytes <= 2'h1;
			end else if (cntNext == fsr_pkg::WORD_BITS && wrMask == fsr_pkg::SR1_MASK) begin
				wrHi <= shNext[7:0];
				wrBytes <= 2'h2;
			end
		end
	end

	// Write latch flag and volatile enable; sets come last and win
	always_ff @(posedge clock) begin
		if (!nrst) begin
			write_latch_flag <= 1'b0;
			volEn <= 1'b0;
		end else begin
			if (nvEnd || extDone || resetCmd) begin
				write_latch_flag <= 1'b0;
			end
			if (opcDone) begin
				volEn <= 1'b0;
				if (opcode == fsr_pkg::OP_WRDI && !busyNow) begin
					write_latch_flag <= 1'b0;
				end
				if (opcode == fsr_pkg::OP_WREN && !busyNow) begin
					write_latch_flag <= 1'b1;
				end
				if (opcode == fsr_pkg::OP_VOL_WREN && !busyNow) begin
					volEn <= 1'b1;
				end
			end
		end
	end

	// Timed write cycle and volatile refresh
	always_ff @(posedge clock) begin
		if (!nrst || resetCmd) begin
			busyCnt <= 20'h00000;
			refreshCnt <= 4'h0;
			pendVal <= fsr_pkg::NV_RESET;
		end else if (commit) begin
			pendVal <= merged;
			if (wrVol) begin
				refreshCnt <= 4'(fsr_pkg::REFRESH_CYCLES);
			end else begin
				busyCnt <= 20'(WRITE_CYCLES);
			end
		end else begin
			if (busyCnt != 20'h00000) begin
				busyCnt <= busyCnt - 20'h00001;
			end
			if (refreshCnt != 4'h0) begin
				refreshCnt <= refreshCnt - 4'h1;
			end
		end
	end

	// Stored and active status copies; reset reloads the stored one
	always_ff @(posedge clock) begin
		if (!nrst) begin
			nvSr <= fsr_pkg::NV_RESET;
			activeSr <= fsr_pkg::NV_RESET;
		end else if (resetCmd) begin
			activeSr <= nvSr;
		end else if (nvEnd) begin
			nvSr <= pendVal;
			activeSr <= pendVal;
		end else if (volEnd) begin
			activeSr <= pendVal;
		end
	end

	// Read parameter for quad-mode dummy count
	always_ff @(posedge clock) begin
		if (!nrst || resetCmd) begin
			readParam <= fsr_pkg::PARAM_RESET;
		end else if (readParamLoad) begin
			readParam <= readParamIn;
		end
	end

	// Registered status word for reads and for the outside
	always_ff @(posedge clock) begin
		if (!nrst) begin
			statusWord <= fsr_pkg::NV_RESET;
		end else begin
			statusWord <= curStatus;
		end
	end
endmodule
`default_nettype wire

//--- tb/fsr_cmd_monitor.sv
// Port checks for the flash status and read command core
`timescale 1ns/1ps
`default_nettype none
module fsr_cmd_monitor #(
	parameter int unsigned WRITE_CYCLES = 20
) (
	// Clock and reset
	input wire logic               clock,
	input wire logic               nrst,
	// Host pins and answer
	input wire fsr_pkg::fsr_pins_s pins,
	input wire logic [3:0]         ioOeN,
	input wire logic               quadMode,
	// Engine and status
	input wire logic               extBusy,
	input wire logic               extDone,
	input wire logic [23:0]        memAddr,
	input wire logic [23:0]        statusWord
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	int unsigned busyCnt;  // Length of a busy stretch not caused by the engine
	logic        extBusyD; // Engine busy a clock ago; the status word lags it by one clock
	// Count own busy cycles; engine busy and its lagging echo restart the count
	always_ff @(posedge clock) begin
		extBusyD <= extBusy;
		if (!nrst || !statusWord[0] || extBusy || extBusyD) begin
			busyCnt <= 0;
		end else begin
			busyCnt <= busyCnt + 1;
		end
	end
	sequence csRise;
		$rose(pins.csN);
	endsequence
	sequence oeFree;
		##[1:5] (ioOeN == 4'hf);
	endsequence
	a_reset_clear: assert property (disable iff (1'b0) !nrst |=> statusWord == 24'h0 && memAddr == 24'h0 && ioOeN == 4'hf)
		else $error("outputs not cleared by reset");
	a_oe_release: assert property (csRise |-> oeFree)
		else $error("output not released after deselect");
	a_oe_idle: assert property (pins.csN [*5] |-> ioOeN == 4'hf)
		else $error("output driven while deselected");
	a_oe_legal: assert property (ioOeN == 4'hf || ioOeN == 4'hd || (quadMode && ioOeN == 4'h0))
		else $error("illegal output enable pattern");
	a_addr_hold: assert property (pins.csN [*6] |=> $stable(memAddr))
		else $error("array address moved outside a frame");
	a_busy_ext: assert property (extBusy [*3] |-> statusWord[0])
		else $error("engine busy not shown");
	a_wel_done: assert property (extDone && pins.csN && $past(pins.csN, 4) |-> ##[1:2] !statusWord[1])
		else $error("latch not cleared on completion");
	a_busy_bound: assert property (busyCnt <= WRITE_CYCLES + 2)
		else $error("timed write too long");
	a_busy_length: assert property ($fell(statusWord[0]) && busyCnt != 0 |-> busyCnt >= WRITE_CYCLES - 2)
		else $error("timed write too short");
endmodule
bind fsr_cmd_core fsr_cmd_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_mon (.clock(clock), .nrst(nrst), .pins(pins),
	.ioOeN(ioOeN), .quadMode(quadMode), .extBusy(extBusy), .extDone(extDone), .memAddr(memAddr),
	.statusWord(statusWord));
`default_nettype wire

//--- tb/fsr_host.sv
// Host controller model that frames instructions on the device pins
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
	// Clock
	input wire logic          clock,
	// Device answer
	input wire logic [3:0]    ioOut,
	input wire logic [3:0]    ioOeN,
	// Device mode: four-line frames when high
	input wire logic          quadMode,
	// Pins towards the device
	output var fsr_pkg::fsr_pins_s pins
);
	logic csN  = 1'b1; // Chip select, idle high
	logic sclk = 1'b0; // Serial clock stands low outside frames
	logic io0  = 1'b0; // Serial_in from the host
	logic fill = 1'b0; // Released data line pattern
	logic [3:0] nib = 4'h0; // Host nibble in four-line mode
	// In single-line mode the released io[1] line moves every cycle so stale data never matches by luck
	always @(posedge clock) fill <= ~fill;
	assign pins = '{csN, sclk, quadMode ? (ioOeN[0] ? nib : ioOut) : {2'b11, ioOeN[1] ? fill : ioOut[1], io0}};
	// Wait edges, then act just after the last one
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Select or release; half periods of five cycles clear the synchronisers
	task automatic sel(input logic on);
		tick(5);
		csN = ~on;
		tick(5);
	endtask
	// One byte MSB first: bit set while clock low, answer taken on the rise
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			io0 = tx[i];
			tick(5);
			sclk = 1'b1;
			rx[i] = pins.io[1];
			tick(5);
			sclk = 1'b0;
		end
	endtask
	// One nibble per serial clock in four-line mode, answer taken on the rise
	task automatic xnib(input logic [3:0] tx, output logic [3:0] rx);
		nib = tx;
		tick(5);
		sclk = 1'b1;
		rx = pins.io;
		tick(5);
		sclk = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb/fsr_cmd_core_tb.sv
// Self-checking bench for the flash status and read command core
`timescale 1ns/1ps
`default_nettype none
module fsr_cmd_core_tb;
	localparam int unsigned WC = 400; // Timed write long enough for a status read inside it
	localparam logic [7:0] WOP [5] = '{8'h01, 8'h01, 8'h31, 8'h11, 8'h31}; // Volatile write opcodes
	localparam int WSH [5] = '{0, 0, 8, 16, 8}; // Register position per case
	logic               clock    = 1'b0; // System clock
	logic               nrst     = 1'b0; // Synchronous reset, active low
	logic               resetCmd = 1'b0; // Reset instruction pulse
	logic               quadMode = 1'b0; // Four-line command mode
	logic               readParamLoad = 1'b0; // Read parameter load pulse
	logic [1:0]         readParamIn   = 2'h0; // Read parameter value
	logic               extBusy  = 1'b0; // Engine busy level
	logic               extDone  = 1'b0; // Engine completion pulse
	fsr_pkg::fsr_pins_s pins;            // Host pins
	logic [3:0]         ioOut;           // Device data
	logic [3:0]         ioOeN;           // Device enables
	logic [23:0]        memAddr;         // Array address
	logic [7:0]         memRdData;       // Array data
	logic [23:0]        statusWord;      // Status at the port
	logic [23:0]        act = '0;        // Model active status
	logic [23:0]        nv  = '0;        // Model stored status
	logic               write_latch_flag = 1'b0;      // Model write latch flag
	logic [23:0]        adr;             // Read start
	logic [23:0]        v;               // Volatile write value
	logic [15:0]        d;               // Random write data
	logic [7:0]         got [$];         // Bytes returned in the last frame
	int                 num_errors = 0;
	int                 num_checks = 0;
	// Array content depends on the address only
	function automatic logic [7:0] pat(input logic [23:0] a);
		return a[7:0] ^ a[23:16] ^ 8'h5a;
	endfunction
	// Writable bits follow the data, one-time bits never fall
	function automatic logic [23:0] merge(input logic [23:0] o, input logic [23:0] n, input logic [23:0] m);
		return (o & ~(fsr_pkg::WRITABLE_MASK & m)) | (n & fsr_pkg::WRITABLE_MASK & m) | (o & fsr_pkg::OTP_MASK);
	endfunction
	function automatic logic [23:0] sw();
		return act | {22'h0, write_latch_flag, 1'b0};
	endfunction
	assign memRdData = pat(memAddr);
	initial forever #5 clock = ~clock;
	fsr_cmd_core #(.WRITE_CYCLES(WC)) i_dut (.clock(clock), .nrst(nrst), .pins(pins), .ioOut(ioOut), .ioOeN(ioOeN),
		.quadMode(quadMode), .readParamLoad(readParamLoad), .readParamIn(readParamIn), .resetCmd(resetCmd),
		.memAddr(memAddr),
		.memRdData(memRdData), .extBusy(extBusy), .extDone(extDone), .statusWord(statusWord));
	fsr_host i_host (.clock(clock), .ioOut(ioOut), .ioOeN(ioOeN), .quadMode(quadMode), .pins(pins));
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Opcode, then n bytes from the top of the value; answers are kept
	task automatic frame(input logic [7:0] op, input int n, input logic [47:0] b);
		logic [7:0] r;
		got = {};
		i_host.sel(1'b1);
		i_host.xbyte(op, r);
		for (int k = 0; k < n; k++) begin
			i_host.xbyte(b[47 - 8 * k -: 8], r);
			got.push_back(r);
		end
		i_host.sel(1'b0);
	endtask
	// Four-line frame: opcode, na bytes of a, dum dummy clocks, nr bytes read back
	task automatic qframe(input logic [7:0] op, input int na, input logic [23:0] a, input int dum, input int nr);
		logic [3:0] r;
		logic [3:0] h;
		got = {};
		i_host.sel(1'b1);
		i_host.xnib(op[7:4], r);
		i_host.xnib(op[3:0], r);
		for (int k = 0; k < 2 * na; k++) i_host.xnib(a[23 - 4 * k -: 4], r);
		for (int k = 0; k < dum; k++) i_host.xnib(4'h0, r);
		for (int k = 0; k < nr; k++) begin
			i_host.xnib(4'h0, h);
			i_host.xnib(4'h0, r);
			got.push_back({h, r});
		end
		i_host.sel(1'b0);
	endtask
	// Let a commit or refresh land before comparing
	task automatic stat(input string what);
		i_host.tick(12);
		check(what, statusWord, sw());
	endtask
	task automatic waitIdle();
		int n;
		for (n = 0; n < WC + 50 && statusWord[0] !== 1'b0; n++) i_host.tick(1);
		if (n == WC + 50) begin
			num_errors++;
			$display("wrong value busy expected 0 seen 1");
			give_verdict();
		end
	endtask
	initial begin
		void'($urandom(75));
		repeat (10) @(posedge clock);
		#1;
		nrst = 1'b1;
		stat("status after reset");
		frame(fsr_pkg::OP_WREN, 0, '0);
		write_latch_flag = 1'b1;
		for (int r = 0; r < 3; r++) begin
			frame(r == 0 ? 8'h05 : r == 1 ? 8'h35 : 8'h15, 2, '0);
			check("status byte", got[0], (sw() >> (8 * r)) & 24'hff);
			check("status repeat", got[1], (sw() >> (8 * r)) & 24'hff);
		end
		frame(fsr_pkg::OP_WRDI, 0, '0);
		write_latch_flag = 1'b0;
		stat("latch after disable");
		frame(8'h31, 1, {8'hff, 40'h0});
		stat("write without latch");
		$display("test latch and status read done");
		d = 16'($urandom);
		frame(fsr_pkg::OP_WREN, 0, '0);
		write_latch_flag = 1'b1;
		frame(8'h01, 2, {d, 32'h0});
		i_host.tick(3);
		check("busy after commit", statusWord[0], 1'b1);
		frame(8'h05, 1, '0);
		check("status during write", got[0], {act[7:2], 2'b11});
		waitIdle();
		nv = merge(nv, {8'h0, d[7:0], d[15:8]}, 24'h00ffff);
		act = nv;
		write_latch_flag = 1'b0;
		stat("status after timed write");
		$display("test timed write done");
		for (int c = 0; c < 5; c++) begin
			d = (c == 4) ? 16'h0 : 16'($urandom);
			frame(8'h50, 0, '0);
			frame(WOP[c], c == 0 ? 2 : 1, {d, 32'h0});
			check("busy during refresh", statusWord[0], 1'b0);
			v = (c == 0) ? {8'h0, d[7:0], d[15:8]} : {16'h0, d[15:8]};
			act = merge(act, v << WSH[c], (c == 0 ? 24'hffff : 24'hff) << WSH[c]);
			stat("status after volatile write");
		end
		resetCmd = 1'b1;
		i_host.tick(1);
		resetCmd = 1'b0;
		act = nv;
		stat("status after reset instruction");
		$display("test volatile write done");
		frame(fsr_pkg::OP_READ, 5, {24'hffffff, 24'h0});
		check("read first byte", got[3], pat(24'hffffff));
		check("read wrapped byte", got[4], pat(24'h0));
		adr = 24'($urandom);
		frame(fsr_pkg::OP_FAST, 6, {adr, 24'h0});
		check("fast read byte", got[4], pat(adr));
		check("fast read next", got[5], pat(adr + 24'h1));
		extBusy = 1'b1;
		frame(fsr_pkg::OP_READ, 4, {24'h123456, 24'h0});
		check("address taken while busy", memAddr === 24'h123456, 1'b0);
		check("busy shown", statusWord[0], 1'b1);
		extBusy = 1'b0;
		$display("test reads done");
		frame(fsr_pkg::OP_WREN, 0, '0);
		extDone = 1'b1;
		i_host.tick(1);
		extDone = 1'b0;
		write_latch_flag = 1'b0;
		stat("latch after completion");
		$display("test completion done");
		quadMode = 1'b1;
		adr = 24'($urandom);
		qframe(fsr_pkg::OP_FAST, 3, adr, 2, 2);
		check("quad default dummies", got[0], pat(adr));
		check("quad next byte", got[1], pat(adr + 24'h1));
		readParamIn = 2'($urandom);
		readParamLoad = 1'b1;
		i_host.tick(1);
		readParamLoad = 1'b0;
		qframe(fsr_pkg::OP_FAST, 3, adr, 2 + 2 * readParamIn, 1);
		check("quad parameter dummies", got[0], pat(adr));
		resetCmd = 1'b1;
		i_host.tick(1);
		resetCmd = 1'b0;
		act = nv;
		qframe(fsr_pkg::OP_FAST, 3, adr, 2, 1);
		check("dummies after reset instruction", got[0], pat(adr));
		qframe(fsr_pkg::OP_READ, 3, 24'h123456, 0, 1);
		check("plain read in quad", memAddr === 24'h123456, 1'b0);
		qframe(8'h50, 0, 24'h0, 0, 0);
		v = act ^ fsr_pkg::QE_MASK;
		qframe(8'h31, 1, {v[15:8], 16'h0}, 0, 0);
		act = merge(act, v, fsr_pkg::SR2_MASK & ~fsr_pkg::QE_MASK);
		stat("quad enable kept in quad mode");
		quadMode = 1'b0;
		$display("test quad mode done");
		give_verdict();
	end
endmodule
`default_nettype wire
